/* include/cfel_pkg.sv */
`default_nettype none
package cfel_pkg;
  // ****************************************
  // Register map
  // ****************************************
  typedef logic [7:0] cfel_addr_t;
  typedef logic [7:0] cfel_data_t;
  localparam cfel_addr_t OFF_STEPDOWN = 8'h22;
  localparam cfel_addr_t OFF_STEPUP = 8'h23;
  localparam cfel_addr_t OFF_MONITOR = 8'h24;
  localparam cfel_addr_t OFF_STATUS = 8'h25;
  localparam cfel_data_t RESET_VALUE = 8'h00;
  localparam int NUM_EV_REGS = 3;
  localparam int REG_STEPDOWN = 0;
  localparam int REG_STEPUP = 1;
  localparam int REG_MONITOR = 2;

  // Reserved read/write bits of the event registers
  localparam cfel_data_t RSV_MASK [NUM_EV_REGS] = '{8'h88, 8'hF8, 8'hEA};

  // ****************************************
  // Event flags: per converter c, index 3c+0 overcurrent, 3c+1 short, 3c+2 good
  // ****************************************
  localparam int NUM_CONV = 3;
  localparam int NUM_MON = 3;
  localparam int NUM_EV = 12;
  localparam int EV_A_ILIM = 0;
  localparam int EV_A_SC = 1;
  localparam int EV_A_PG = 2;
  localparam int EV_B_ILIM = 3;
  localparam int EV_B_SC = 4;
  localparam int EV_B_PG = 5;
  localparam int EV_UP_ILIM = 6;
  localparam int EV_UP_SC = 7;
  localparam int EV_UP_PG = 8;
  localparam int EV_MON_A = 9;
  localparam int EV_MON_B = 10;
  localparam int EV_ANA = 11;
  localparam int EV_REG [NUM_EV] = '{0, 0, 0, 0, 0, 0, 1, 1, 1, 2, 2, 2};
  localparam int EV_BIT [NUM_EV] = '{0, 1, 2, 4, 5, 6, 0, 1, 2, 2, 4, 0};

  // ****************************************
  // Live status bits
  // ****************************************
  localparam int ST_OVP = 0;
  localparam int ST_WARN = 1;
  localparam int ST_TSD = 2;
  localparam int ST_CLK_BAD = 3;
  localparam int NUM_ST = 4;

  // ****************************************
  // Synchroniser bank layout
  // ****************************************
  localparam int SY_ILIM = 0;
  localparam int SY_PG = 3;
  localparam int SY_MON = 6;
  localparam int SY_ABOVE = 9;
  localparam int SY_STAT = 12;
  localparam int SY_W = 16;

  // ****************************************
  // Start-up window
  // ****************************************
  localparam int CLK_MHZ = 40;
  localparam int START_TIME_US = 1000;
  localparam int START_CYCLES = START_TIME_US * CLK_MHZ;
  localparam int CNT_W = 16;

  typedef enum logic [1:0] {
    SC_OFF = 2'b00,
    SC_START = 2'b01,
    SC_RUN = 2'b11
  } cfel_sc_state_e;
endpackage : cfel_pkg
`default_nettype wire

/* logic/cfel_flag_latch.sv */
`timescale 1ns/1ps
`default_nettype none
module cfel_flag_latch (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_cond,
  input wire logic i_clr,
  output logic o_flag
);
  logic cond_d_r;
  logic cond_d_nxt;
  logic flag_nxt;

  // Edge set beats a same-cycle clear
  always_comb begin
    cond_d_nxt = i_cond;
    flag_nxt = (o_flag & ~i_clr) | (i_cond & ~cond_d_r);
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      cond_d_r <= 1'b0;
      o_flag <= 1'b0;
    end else begin
      cond_d_r <= cond_d_nxt;
      o_flag <= flag_nxt;
    end
  end
endmodule : cfel_flag_latch
`default_nettype wire

/* logic/cfel_top.sv */
// Behaviour
// - Converter A good event latches bit 2
// - Converter B good event latches bit 6
// - Converter A short latches bit 1
// - Converter B short latches bit 5
// - Converter A overcurrent latches bit 0
// - Converter B overcurrent latches bit 4
// - Step-up good event latches bit 2
// - Step-up short latches bit 1
// - Step-up overcurrent latches bit 0
// - Monitor B good event latches bit 4
// - Monitor A good event latches bit 2
// - Analog supply good event latches bit 0
// - Status bit 3 shows sync clock invalid
// - Status bit 2 shows thermal shutdown live
// - Status bit 1 shows thermal warning live
// - Status bit 0 shows input overvoltage live
// - All registers reset to zero
// - Group summaries follow non-zero event bits of the group registers; reserved bits are ignored
`timescale 1ns/1ps
`default_nettype none
module cfel_top #(
  parameter int P_START_CYCLES = cfel_pkg::START_CYCLES
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire cfel_pkg::cfel_addr_t i_reg_addr,
  input wire logic i_reg_wr,
  input wire cfel_pkg::cfel_data_t i_reg_wdata,
  input wire logic i_conv_a_en,
  input wire logic i_conv_b_en,
  input wire logic i_stepup_en,
  input wire logic i_conv_a_ilim,
  input wire logic i_conv_b_ilim,
  input wire logic i_stepup_ilim,
  input wire logic i_conv_a_pg,
  input wire logic i_conv_b_pg,
  input wire logic i_stepup_pg,
  input wire logic i_ext_mon_a_pg,
  input wire logic i_ext_mon_b_pg,
  input wire logic i_analog_supply_pg,
  input wire logic i_conv_a_above_sc,
  input wire logic i_conv_b_above_sc,
  input wire logic i_stepup_above_sc,
  input wire logic i_input_overvoltage,
  input wire logic i_thermal_warning,
  input wire logic i_thermal_shutdown,
  input wire logic i_ext_sync_clock_bad,
  output cfel_pkg::cfel_data_t o_reg_rdata,
  output logic o_stepdown_summary_flag,
  output logic o_stepup_summary_flag,
  output logic o_monitor_summary_flag
);
  import cfel_pkg::*;

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [SY_W-1:0] sy1_r;
  logic [SY_W-1:0] sy1_nxt;
  logic [SY_W-1:0] sy2_r;
  logic [SY_W-1:0] sy2_nxt;

  always_comb begin
    sy1_nxt = {i_ext_sync_clock_bad, i_thermal_shutdown, i_thermal_warning,
               i_input_overvoltage, i_stepup_above_sc, i_conv_b_above_sc,
               i_conv_a_above_sc, i_analog_supply_pg, i_ext_mon_b_pg,
               i_ext_mon_a_pg, i_stepup_pg, i_conv_b_pg, i_conv_a_pg,
               i_stepup_ilim, i_conv_b_ilim, i_conv_a_ilim};
    sy2_nxt = sy1_r;
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      sy1_r <= '0;
      sy2_r <= '0;
    end else begin
      sy1_r <= sy1_nxt;
      sy2_r <= sy2_nxt;
    end
  end

  // ****************************************
  // Short-circuit detection per converter
  // ****************************************
  logic [NUM_CONV-1:0] conv_en;
  logic [NUM_CONV-1:0] sc_cond;
  cfel_sc_state_e sc_state_r [NUM_CONV];
  logic [CNT_W-1:0] sc_cnt_r [NUM_CONV];

  assign conv_en = {i_stepup_en, i_conv_b_en, i_conv_a_en};

  // Timeout falls into the run state, so a missed start looks like a drop
  for (genvar c = 0; c < NUM_CONV; c++) begin : g_sc
    cfel_sc_state_e state_nxt;
    logic [CNT_W-1:0] cnt_nxt;
    logic above;

    assign above = sy2_r[SY_ABOVE+c];

    always_comb begin
      state_nxt = sc_state_r[c];
      cnt_nxt = sc_cnt_r[c];
      unique case (sc_state_r[c])
        SC_OFF: begin
          cnt_nxt = '0;
          if (conv_en[c]) begin
            state_nxt = SC_START;
          end
        end
        SC_START: begin
          if (!conv_en[c]) begin
            state_nxt = SC_OFF;
          end else if (above || sc_cnt_r[c] == CNT_W'(P_START_CYCLES)) begin
            state_nxt = SC_RUN;
          end else begin
            cnt_nxt = sc_cnt_r[c] + 1'b1;
          end
        end
        SC_RUN: begin
          if (!conv_en[c]) begin
            state_nxt = SC_OFF;
          end
        end
        default: begin
          state_nxt = SC_OFF;
        end
      endcase
    end

    // Below threshold while running, or never reached it in time
    assign sc_cond[c] = (sc_state_r[c] == SC_RUN) && !above;

    always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
        sc_state_r[c] <= SC_OFF;
        sc_cnt_r[c] <= '0;
      end else begin
        sc_state_r[c] <= state_nxt;
        sc_cnt_r[c] <= cnt_nxt;
      end
    end
  end

  // ****************************************
  // Event conditions and clear decode
  // ****************************************
  logic [NUM_EV-1:0] ev_cond;
  logic [NUM_EV-1:0] ev_clr;
  logic [NUM_EV-1:0] ev_flag;
  cfel_addr_t ev_off [NUM_EV_REGS];

  assign ev_off = '{OFF_STEPDOWN, OFF_STEPUP, OFF_MONITOR};

  for (genvar c = 0; c < NUM_CONV; c++) begin : g_conv_ev
    assign ev_cond[3*c] = sy2_r[SY_ILIM+c];
    assign ev_cond[3*c+1] = sc_cond[c];
    assign ev_cond[3*c+2] = sy2_r[SY_PG+c];
  end

  for (genvar m = 0; m < NUM_MON; m++) begin : g_mon_ev
    assign ev_cond[EV_MON_A+m] = sy2_r[SY_MON+m];
  end

  // Only a one clears; a zero bit leaves the flag alone
  for (genvar e = 0; e < NUM_EV; e++) begin : g_ev
    assign ev_clr[e] = i_reg_wr && i_reg_addr == ev_off[EV_REG[e]]
                       && i_reg_wdata[EV_BIT[e]];

    cfel_flag_latch u_flag (
      .i_mclk(i_mclk),
      .i_rst_n(i_rst_n),
      .i_cond(ev_cond[e]),
      .i_clr(ev_clr[e]),
      .o_flag(ev_flag[e])
    );
  end

  // ****************************************
  // Register state and readback
  // ****************************************
  cfel_data_t rsv_r [NUM_EV_REGS];
  cfel_data_t rsv_nxt [NUM_EV_REGS];
  cfel_data_t ev_rd [NUM_EV_REGS];
  logic [NUM_ST-1:0] status_r;
  logic [NUM_ST-1:0] status_nxt;
  logic [NUM_EV_REGS-1:0] summ_r;
  logic [NUM_EV_REGS-1:0] summ_nxt;
  cfel_data_t rdata_nxt;

  always_comb begin
    for (int r = 0; r < NUM_EV_REGS; r++) begin
      rsv_nxt[r] = rsv_r[r];
      if (i_reg_wr && i_reg_addr == ev_off[r]) begin
        rsv_nxt[r] = i_reg_wdata & RSV_MASK[r];
      end
      ev_rd[r] = rsv_r[r];
    end
    for (int e = 0; e < NUM_EV; e++) begin
      ev_rd[EV_REG[e]][EV_BIT[e]] = ev_flag[e];
    end
    // Summaries ignore reserved bits, which carry no event
    for (int r = 0; r < NUM_EV_REGS; r++) begin
      summ_nxt[r] = |(ev_rd[r] & ~RSV_MASK[r]);
    end
    // Live status is not latched, only synchronised
    status_nxt = sy2_r[SY_STAT +: NUM_ST];
    unique case (i_reg_addr)
      OFF_STEPDOWN: rdata_nxt = ev_rd[REG_STEPDOWN];
      OFF_STEPUP: rdata_nxt = ev_rd[REG_STEPUP];
      OFF_MONITOR: rdata_nxt = ev_rd[REG_MONITOR];
      OFF_STATUS: rdata_nxt = {4'h0, status_r};
      default: rdata_nxt = RESET_VALUE;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      for (int r = 0; r < NUM_EV_REGS; r++) begin
        rsv_r[r] <= RESET_VALUE;
      end
      status_r <= '0;
      summ_r <= '0;
      o_reg_rdata <= RESET_VALUE;
    end else begin
      for (int r = 0; r < NUM_EV_REGS; r++) begin
        rsv_r[r] <= rsv_nxt[r];
      end
      status_r <= status_nxt;
      summ_r <= summ_nxt;
      o_reg_rdata <= rdata_nxt;
    end
  end

  assign o_stepdown_summary_flag = summ_r[REG_STEPDOWN];
  assign o_stepup_summary_flag = summ_r[REG_STEPUP];
  assign o_monitor_summary_flag = summ_r[REG_MONITOR];

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  a_conv_a_good: assert property ($rose(sy2_r[SY_PG]) |=> ev_flag[EV_A_PG])
    else $error("converter A good event not latched");
  a_conv_b_good: assert property ($rose(sy2_r[SY_PG+1]) |=> ev_flag[EV_B_PG])
    else $error("converter B good event not latched");
  a_conv_a_short: assert property (
    sc_state_r[0] == SC_START && conv_en[0] && !sy2_r[SY_ABOVE]
    && sc_cnt_r[0] == CNT_W'(P_START_CYCLES) |=> ##1 ev_flag[EV_A_SC])
    else $error("converter A start timeout not flagged");
  a_conv_b_short: assert property (
    sc_state_r[1] == SC_RUN && conv_en[1] && $fell(sy2_r[SY_ABOVE+1])
    |=> ev_flag[EV_B_SC])
    else $error("converter B drop not flagged");
  a_conv_a_ilim: assert property ($rose(sy2_r[SY_ILIM]) |=> ev_flag[EV_A_ILIM])
    else $error("converter A overcurrent not latched");
  a_conv_b_ilim: assert property ($rose(sy2_r[SY_ILIM+1]) |=> ev_flag[EV_B_ILIM])
    else $error("converter B overcurrent not latched");
  a_stepup_good: assert property ($rose(sy2_r[SY_PG+2]) |=> ev_flag[EV_UP_PG])
    else $error("step-up good event not latched");
  a_stepup_short: assert property ($rose(sc_cond[2]) |=> ev_flag[EV_UP_SC])
    else $error("step-up short not latched");
  a_stepup_ilim: assert property ($rose(sy2_r[SY_ILIM+2]) |=> ev_flag[EV_UP_ILIM])
    else $error("step-up overcurrent not latched");
  a_mon_events: assert property ($rose(sy2_r[SY_MON+1]) |=> ev_flag[EV_MON_B])
    else $error("monitor B good event not latched");
  a_mon_a_event: assert property ($rose(sy2_r[SY_MON]) |=> ev_flag[EV_MON_A])
    else $error("monitor A good event not latched");
  a_analog_event: assert property ($rose(sy2_r[SY_MON+2]) |=> ev_flag[EV_ANA])
    else $error("analog supply good event not latched");
  a_status_read: assert property (i_reg_addr == OFF_STATUS
    |=> o_reg_rdata == {4'h0, $past(status_r)})
    else $error("status readback wrong");
  a_status_live: assert property (status_r == $past(sy2_r[SY_STAT +: NUM_ST], 1))
    else $error("status bits not live");
  a_summary_track: assert property ((ev_flag[2:0] == 3'h0 && ev_flag[5:3] == 3'h0)
    |=> !o_stepdown_summary_flag)
    else $error("step-down summary stuck");
  a_stepup_summary: assert property (ev_flag[8:6] != 3'h0 |=> o_stepup_summary_flag)
    else $error("step-up summary not raised");
  a_mon_summary: assert property (ev_flag[11:9] != 3'h0 |=> o_monitor_summary_flag)
    else $error("monitor summary not raised");
  a_flag_hold: assert property (ev_flag[EV_A_PG] && !ev_clr[EV_A_PG]
    |=> ev_flag[EV_A_PG])
    else $error("flag lost without a clear");
  a_clear_works: assert property (ev_clr[EV_B_ILIM] && !$rose(sy2_r[SY_ILIM+1])
    |=> !ev_flag[EV_B_ILIM])
    else $error("write of one did not clear");
  a_level_no_reset: assert property (ev_clr[EV_ANA] && $stable(sy2_r[SY_MON+2])
    ##1 $stable(sy2_r[SY_MON+2]) |-> !ev_flag[EV_ANA])
    else $error("steady level set flag again");

  c_short_timeout: cover property (sc_state_r[0] == SC_START ##1 sc_state_r[0] == SC_RUN
    ##1 ev_flag[EV_A_SC]);
  c_set_and_clear: cover property (ev_clr[EV_A_ILIM] && $rose(sy2_r[SY_ILIM]));
  c_summary_drop: cover property ($fell(o_monitor_summary_flag));
  c_status_hot: cover property (status_r[ST_TSD] && status_r[ST_WARN]);
endmodule : cfel_top
`default_nettype wire

/* verification/cfel_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Host side of the register access
// ****************************************
module cfel_host_model (
  input wire logic i_mclk,
  input wire cfel_pkg::cfel_data_t i_reg_rdata,
  output cfel_pkg::cfel_addr_t o_reg_addr,
  output logic o_reg_wr,
  output cfel_pkg::cfel_data_t o_reg_wdata
);
  import cfel_pkg::*;
  initial begin
    o_reg_addr = 8'h00;
    o_reg_wr = 1'h0;
    o_reg_wdata = 8'h00;
  end
  // One-cycle strobe, held through the taking edge
  task automatic wr(input cfel_addr_t a, input cfel_data_t d);
    @(posedge i_mclk);
    o_reg_addr <= a;
    o_reg_wr <= 1'h1;
    o_reg_wdata <= d;
    @(posedge i_mclk);
    o_reg_wr <= 1'h0;
    // Released data must not keep showing the old value
    o_reg_wdata <= ~d;
  endtask : wr
  // Read data is registered: one edge after the address
  // Returns on a rising edge so callers drive stimulus there
  task automatic rd(input cfel_addr_t a, output cfel_data_t d);
    @(posedge i_mclk);
    o_reg_addr <= a;
    @(posedge i_mclk);
    @(negedge i_mclk);
    d = i_reg_rdata;
    @(posedge i_mclk);
  endtask : rd
endmodule : cfel_host_model
`default_nettype wire

/* verification/tb_converter_fault_event_latches.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) begin n_compared++; if ((got) !== (exp)) begin miscompares++; \
  $display("Error %s expected %0h seen %0h", what, exp, got); end end
// ****************************************
// Bench for the event latches
// ****************************************
module tb_converter_fault_event_latches;
  import cfel_pkg::*;
  localparam int START_N = 20;
  logic i_mclk;
  logic i_rst_n;
  cfel_addr_t reg_addr;
  logic reg_wr;
  cfel_data_t reg_wdata;
  cfel_data_t reg_rdata;
  cfel_data_t d;
  logic [NUM_EV-1:0] cond;
  logic [NUM_CONV-1:0] en;
  logic [NUM_CONV-1:0] above;
  logic [2:0] summ;
  logic [NUM_ST-1:0] st;
  int miscompares = 0;
  int n_compared = 0;
  int pulse_ev [9] = '{0, 2, 3, 5, 6, 8, 9, 10, 11};

  cfel_host_model cfel_host_model_inst (.i_mclk(i_mclk), .i_reg_rdata(reg_rdata),
    .o_reg_addr(reg_addr), .o_reg_wr(reg_wr), .o_reg_wdata(reg_wdata));
  cfel_top #(.P_START_CYCLES(START_N)) cfel_top_inst (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_reg_addr(reg_addr), .i_reg_wr(reg_wr), .i_reg_wdata(reg_wdata),
    .i_conv_a_en(en[0]), .i_conv_b_en(en[1]), .i_stepup_en(en[2]),
    .i_conv_a_ilim(cond[EV_A_ILIM]), .i_conv_b_ilim(cond[EV_B_ILIM]),
    .i_stepup_ilim(cond[EV_UP_ILIM]), .i_conv_a_pg(cond[EV_A_PG]),
    .i_conv_b_pg(cond[EV_B_PG]), .i_stepup_pg(cond[EV_UP_PG]),
    .i_ext_mon_a_pg(cond[EV_MON_A]), .i_ext_mon_b_pg(cond[EV_MON_B]),
    .i_analog_supply_pg(cond[EV_ANA]), .i_conv_a_above_sc(above[0]),
    .i_conv_b_above_sc(above[1]), .i_stepup_above_sc(above[2]),
    .i_input_overvoltage(st[ST_OVP]), .i_thermal_warning(st[ST_WARN]),
    .i_thermal_shutdown(st[ST_TSD]), .i_ext_sync_clock_bad(st[ST_CLK_BAD]),
    .o_reg_rdata(reg_rdata), .o_stepdown_summary_flag(summ[0]),
    .o_stepup_summary_flag(summ[1]), .o_monitor_summary_flag(summ[2]));

  initial begin
    i_mclk = 1'h0;
    forever #12.5 i_mclk = ~i_mclk;
  end

  task automatic end_sim;
    $display("Comparisons %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim

  // Zero reset, read-only status, unmapped space, reserved storage
  task automatic t_reset_map;
    for (int r = 0; r < 4; r++) begin
      cfel_host_model_inst.rd(OFF_STEPDOWN + 8'(r), d);
      `CHK("reset value", 8'h00, d)
    end
    `CHK("summary reset", 3'h0, summ)
    cfel_host_model_inst.wr(OFF_STATUS, 8'hFF);
    cfel_host_model_inst.rd(OFF_STATUS, d);
    `CHK("status after write", 8'h00, d)
    cfel_host_model_inst.rd(8'h30, d);
    `CHK("unmapped read", 8'h00, d)
    cfel_host_model_inst.wr(OFF_STEPDOWN, 8'h88);
    cfel_host_model_inst.rd(OFF_STEPDOWN, d);
    `CHK("reserved storage", 8'h88, d)
    `CHK("summary ignores reserved", 1'h0, summ[0])
    cfel_host_model_inst.wr(OFF_STEPDOWN, 8'h00);
  endtask : t_reset_map

  // Each pulse event: latch, zero write, clear under a standing level
  task automatic t_events;
    int e;
    cfel_data_t bitv;
    cfel_addr_t a;
    for (int i = 0; i < 9; i++) begin
      e = pulse_ev[i];
      bitv = 8'h01 << EV_BIT[e];
      a = OFF_STEPDOWN + 8'(EV_REG[e]);
      @(posedge i_mclk);
      cond[e] <= 1'h1;
      repeat (6) @(posedge i_mclk);
      cfel_host_model_inst.rd(a, d);
      `CHK("event latched", bitv, d)
      `CHK("group summary set", 1'h1, summ[EV_REG[e]])
      cfel_host_model_inst.wr(a, 8'h00);
      cfel_host_model_inst.rd(a, d);
      `CHK("zero write keeps", bitv, d)
      cfel_host_model_inst.wr(a, bitv);
      repeat (4) @(posedge i_mclk);
      cfel_host_model_inst.rd(a, d);
      `CHK("cleared under level", 8'h00, d)
      `CHK("group summary clear", 1'h0, summ[EV_REG[e]])
      cond[e] <= 1'h0;
      repeat (4) @(posedge i_mclk);
    end
  endtask : t_events

  // New edge in the very cycle of the clear
  task automatic t_set_wins;
    @(posedge i_mclk);
    cond[EV_A_ILIM] <= 1'h1;
    repeat (6) @(posedge i_mclk);
    cond[EV_A_ILIM] <= 1'h0;
    repeat (6) @(posedge i_mclk);
    cond[EV_A_ILIM] <= 1'h1;
    @(posedge i_mclk);
    cfel_host_model_inst.wr(OFF_STEPDOWN, 8'h01);
    cfel_host_model_inst.rd(OFF_STEPDOWN, d);
    `CHK("set beats clear", 8'h01, d)
    cond[EV_A_ILIM] <= 1'h0;
    cfel_host_model_inst.wr(OFF_STEPDOWN, 8'h01);
  endtask : t_set_wins

  // Short: drop while running, then missed start-up window
  task automatic t_short;
    cfel_data_t bitv;
    cfel_addr_t a;
    for (int c = 0; c < NUM_CONV; c++) begin
      bitv = 8'h01 << EV_BIT[3 * c + 1];
      a = OFF_STEPDOWN + 8'(EV_REG[3 * c + 1]);
      @(posedge i_mclk);
      above[c] <= 1'h1;
      en[c] <= 1'h1;
      repeat (START_N + 10) @(posedge i_mclk);
      cfel_host_model_inst.rd(a, d);
      `CHK("no short while good", 8'h00, d)
      above[c] <= 1'h0;
      repeat (6) @(posedge i_mclk);
      cfel_host_model_inst.rd(a, d);
      `CHK("short while running", bitv, d)
      en[c] <= 1'h0;
      cfel_host_model_inst.wr(a, bitv);
      repeat (4) @(posedge i_mclk);
      en[c] <= 1'h1;
      repeat (START_N - 6) @(posedge i_mclk);
      cfel_host_model_inst.rd(a, d);
      `CHK("inside start window", 8'h00, d)
      repeat (12) @(posedge i_mclk);
      cfel_host_model_inst.rd(a, d);
      `CHK("start window missed", bitv, d)
      en[c] <= 1'h0;
      cfel_host_model_inst.wr(a, bitv);
    end
  endtask : t_short

  // Live status follows each input both ways
  task automatic t_status;
    for (int b = 0; b < NUM_ST; b++) begin
      @(posedge i_mclk);
      st[b] <= 1'h1;
      repeat (5) @(posedge i_mclk);
      cfel_host_model_inst.rd(OFF_STATUS, d);
      `CHK("status live", 8'h01 << b, d)
      st[b] <= 1'h0;
      repeat (5) @(posedge i_mclk);
      cfel_host_model_inst.rd(OFF_STATUS, d);
      `CHK("status not latched", 8'h00, d)
    end
    // Warning and shutdown together, as a hot die shows them
    st <= 4'h6;
    repeat (5) @(posedge i_mclk);
    cfel_host_model_inst.rd(OFF_STATUS, d);
    `CHK("status warm and hot", 8'h06, d)
    st <= 4'h0;
  endtask : t_status

  initial begin
    i_rst_n = 1'h0;
    cond = '0;
    en = '0;
    above = '0;
    st = '0;
    repeat (20) @(posedge i_mclk);
    i_rst_n <= 1'h1;
    repeat (2) @(posedge i_mclk);
    t_reset_map();
    t_events();
    t_set_wins();
    t_short();
    t_status();
    end_sim();
  end

  // Whole run needs well under 2000 cycles
  initial begin
    repeat (6000) @(posedge i_mclk);
    miscompares++;
    end_sim();
  end
endmodule : tb_converter_fault_event_latches
`default_nettype wire
